// ===== src/smpp_consts.vh
// constants for the serial memory programming port
`ifndef SMPP_CONSTS_VH
`define SMPP_CONSTS_VH
`define SMPP_OP_ENABLE_B1 8'hac
`define SMPP_OP_ENABLE_B2 8'h53
`define SMPP_OP_ERASE_B2_TOP 3'h4
`define SMPP_OP_LOCK_B2_TOP 3'h7
`define SMPP_OP_PRD_TOP 4'h2
`define SMPP_OP_PWR_TOP 4'h4
`define SMPP_OP_ERD 8'ha0
`define SMPP_OP_EWR 8'hc0
`define SMPP_OP_SIG 8'h30
`define SMPP_PROG_WORDS 4096
`define SMPP_EE_BYTES 512
`define SMPP_ERASED 8'hff
`define SMPP_EE_ERASE_POLL 8'h80
`define SMPP_EE_WRITE_POLL 8'h7f
`define SMPP_PROG_POLL 8'h7f
`define SMPP_CLK_MHZ 100
`define SMPP_ERASE_WAIT_US 8000
`define SMPP_WRITE_WAIT_US 4000
`define SMPP_ERASE_CYC (`SMPP_ERASE_WAIT_US * `SMPP_CLK_MHZ)
`define SMPP_WRITE_CYC (`SMPP_WRITE_WAIT_US * `SMPP_CLK_MHZ)
`endif

// ===== src/smpp_buf2.v
// two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module smpp_buf2 (
	input wire clk_in,
	input wire rst_n_in,
	input wire [7:0] in_data_in,
	input wire in_valid_in,
	output wire in_ready_out,
	output wire [7:0] out_data_out,
	output wire out_valid_out,
	input wire out_ready_in
);
	reg [7:0] mem_r [0:1];
	reg rd_r;
	reg wr_r;
	reg [1:0] cnt_r;
	wire push;
	wire pop;
	assign in_ready_out = (cnt_r != 2'd2);
	assign out_valid_out = (cnt_r != 2'd0);
	assign out_data_out = mem_r[rd_r];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	// pointer and count update
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			rd_r <= 1'b0;
			wr_r <= 1'b0;
			cnt_r <= 2'd0;
			mem_r[0] <= 8'h00;
			mem_r[1] <= 8'h00;
		end else begin
			if (push) begin
				mem_r[wr_r] <= in_data_in;
				wr_r <= ~wr_r;
			end
			if (pop)
				rd_r <= ~rd_r;
			if (push && !pop)
				cnt_r <= cnt_r + 2'd1;
			else if (pop && !push)
				cnt_r <= cnt_r - 2'd1;
		end
	end
endmodule
`default_nettype wire

// ===== src/smpp_port.v
// serial programming port: sampler, instruction decode, memories, busy timing
`timescale 1ns/1ps
`default_nettype none
`include "smpp_consts.vh"
// Behaviour
// - programming only while reset pin low; enable instruction must come first (here only writes, chip erase and lock write wait for it; reads run without it)
// - eeprom write erases its own location, self-timed
// - chip erase sets program memory and eeprom to all ones
// - program words to 0x0fff, eeprom bytes to 0x01ff, separate spaces
// - sample input on rising clock edge, change output on falling edge
// - echo 0x53 during third byte of enable; programmer sends all four bytes
// - one byte per write; programmer polls or waits before next instruction
// - read returns addressed content on serial output
// - eeprom poll reads 0x80 while erasing, 0x7f while writing, then data
// - program memory poll reads 0x7f until done; 0x7f writes need waiting
// - 0xac,0x53 is enable; 0xac,100xxxxx is chip erase
// - program read/write use bit h for byte; address bytes 2,3, data 4
// - eeprom read/write take address bit 8 from byte 2 lsb, low from 3
// - lock write programs lock bit when its byte 2 bit is zero
// - signature read returns selected byte unless both lock bits programmed
module smpp_port #(
	parameter ERASE_CYC = `SMPP_ERASE_CYC,
	parameter WRITE_CYC = `SMPP_WRITE_CYC,
	parameter [7:0] SIG0 = 8'h1e, // signature values are arbitrary
	parameter [7:0] SIG1 = 8'h55,
	parameter [7:0] SIG2 = 8'h2a
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire reset_n_pin_in,
	input wire sck_in,
	input wire mosi_in,
	output wire miso_out,
	output wire miso_oe_out,
	output wire prog_mode_out,
	output wire busy_out,
	output wire [7:0] instr_byte_out,
	output wire instr_valid_out,
	input wire instr_ready_in
);
	localparam ST_IDLE = 3'b001;
	localparam ST_ERASE = 3'b010;
	localparam ST_WRITE = 3'b100;
	reg [7:0] prog_lo_r [0:`SMPP_PROG_WORDS-1];
	reg [7:0] prog_hi_r [0:`SMPP_PROG_WORDS-1];
	reg [7:0] ee_r [0:`SMPP_EE_BYTES-1];
	reg [2:0] sck_sync_r;
	reg [1:0] rst_sync_r;
	reg [1:0] mosi_sync_r;
	reg [7:0] sh_r;
	reg [2:0] bitc_r;
	reg [1:0] bytec_r;
	reg [7:0] b1_r;
	reg [7:0] b2_r;
	reg [7:0] b3_r;
	reg [7:0] out_sh_r;
	reg miso_r;
	reg enabled_r;
	reg lock1_r;
	reg lock2_r;
	reg [2:0] state_r;
	reg [31:0] cnt_r;
	reg [12:0] erase_idx_r;
	reg wr_is_ee_r;
	reg wr_hi_r;
	reg [11:0] wr_addr_r;
	reg [7:0] wr_data_r;
	reg [7:0] rd_val;
	reg [7:0] buf_data_r;
	reg buf_valid_r;
	wire in_prog;
	wire sck_rise;
	wire sck_fall;
	wire [7:0] full_byte;
	wire byte_done;
	wire buf_ready;
	wire [7:0] b3_cur;
	// poll-aware read of current target
	function [7:0] poll_mux;
		input busy_match;
		input [7:0] poll_val;
		input [7:0] mem_val;
		begin
			poll_mux = busy_match ? poll_val : mem_val;
		end
	endfunction
	// program memory opcode: given top nibble, bits 2..0 clear, bit 3 picks the byte
	function is_prog_op;
		input [7:0] op;
		input [3:0] top;
		begin
			is_prog_op = (op[7:4] == top) && (op[2:0] == 3'b000);
		end
	endfunction
	// program word address from bytes 2 and 3
	function [11:0] prog_addr;
		input [7:0] hi;
		input [7:0] lo;
		begin
			prog_addr = {hi[3:0], lo};
		end
	endfunction
	// eeprom byte address from bytes 2 and 3
	function [8:0] ee_addr;
		input [7:0] hi;
		input [7:0] lo;
		begin
			ee_addr = {hi[0], lo};
		end
	endfunction
	// two-stage synchronisers, third stage for edge finding
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			sck_sync_r <= 3'b000;
			rst_sync_r <= 2'b11;
			mosi_sync_r <= 2'b00;
		end else begin
			sck_sync_r <= {sck_sync_r[1:0], sck_in};
			rst_sync_r <= {rst_sync_r[0], reset_n_pin_in};
			mosi_sync_r <= {mosi_sync_r[0], mosi_in};
		end
	end
	// session flag, serial edges and the byte being completed
	assign in_prog = ~rst_sync_r[1];
	assign sck_rise = in_prog && sck_sync_r[1] && !sck_sync_r[2];
	assign sck_fall = in_prog && !sck_sync_r[1] && sck_sync_r[2];
	assign full_byte = {sh_r[6:0], mosi_sync_r[1]};
	assign byte_done = sck_rise && (bitc_r == 3'd7);
	// byte 3 as it stands on its own last edge, so a read sees its fresh address
	assign b3_cur = (bytec_r == 2'd2) ? full_byte : b3_r;
	// read value for a read instruction given bytes 1..3
	always @* begin
		rd_val = 8'h00;
		if (is_prog_op(b1_r, `SMPP_OP_PRD_TOP)) begin
			rd_val = b1_r[3] ? prog_hi_r[prog_addr(b2_r, b3_cur)]
				: prog_lo_r[prog_addr(b2_r, b3_cur)];
			rd_val = poll_mux(state_r == ST_WRITE && !wr_is_ee_r && wr_hi_r == b1_r[3]
				&& wr_addr_r == prog_addr(b2_r, b3_cur), `SMPP_PROG_POLL, rd_val);
		end else if (b1_r == `SMPP_OP_ERD) begin
			rd_val = ee_r[ee_addr(b2_r, b3_cur)];
			if (state_r == ST_WRITE && wr_is_ee_r && wr_addr_r[8:0] == ee_addr(b2_r, b3_cur))
				rd_val = (cnt_r >= WRITE_CYC / 2) ? `SMPP_EE_ERASE_POLL
					: `SMPP_EE_WRITE_POLL;
		end else if (b1_r == `SMPP_OP_SIG && !(lock1_r && lock2_r)) begin
			case (b3_cur[1:0])
				2'd0: rd_val = SIG0;
				2'd1: rd_val = SIG1;
				2'd2: rd_val = SIG2;
				default: rd_val = 8'h00;
			endcase
		end
	end
	// serial shifter and instruction execution
	always @(posedge clk_in) begin
		if (!rst_n_in || !in_prog) begin
			sh_r <= 8'h00;
			bitc_r <= 3'd0;
			bytec_r <= 2'd0;
			b1_r <= 8'h00;
			b2_r <= 8'h00;
			b3_r <= 8'h00;
			out_sh_r <= 8'h00;
			miso_r <= 1'b0;
			enabled_r <= 1'b0;
			buf_valid_r <= 1'b0;
			buf_data_r <= 8'h00;
		end else begin
			if (buf_valid_r && buf_ready)
				buf_valid_r <= 1'b0;
			if (sck_fall) begin
				miso_r <= out_sh_r[7];
				out_sh_r <= {out_sh_r[6:0], 1'b0};
			end
			if (sck_rise) begin
				sh_r <= full_byte;
				bitc_r <= bitc_r + 3'd1;
			end
			if (byte_done) begin
				bytec_r <= bytec_r + 2'd1;
				buf_data_r <= full_byte;
				buf_valid_r <= 1'b1;
				case (bytec_r)
					2'd0: b1_r <= full_byte;
					2'd1: begin
						b2_r <= full_byte;
						out_sh_r <= full_byte;
					end
					2'd2: begin
						b3_r <= full_byte;
					end
					default: begin
						if (b1_r == `SMPP_OP_ENABLE_B1 && b2_r == `SMPP_OP_ENABLE_B2)
							enabled_r <= 1'b1;
					end
				endcase
			end
			// byte 3 done: load read data so it leaves with byte 4
			if (sck_rise && bitc_r == 3'd7 && bytec_r == 2'd2)
				out_sh_r <= rd_val;
		end
	end
	// memory writes, chip erase and busy timing
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_r <= ST_IDLE;
			cnt_r <= 32'd0;
			erase_idx_r <= 13'd0;
			wr_is_ee_r <= 1'b0;
			wr_hi_r <= 1'b0;
			wr_addr_r <= 12'h000;
			wr_data_r <= 8'h00;
			lock1_r <= 1'b0;
			lock2_r <= 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (byte_done && bytec_r == 2'd3 && enabled_r) begin
						if (b1_r == `SMPP_OP_ENABLE_B1 && b2_r[7:5] == `SMPP_OP_ERASE_B2_TOP) begin
							state_r <= ST_ERASE;
							cnt_r <= ERASE_CYC;
							erase_idx_r <= 13'd0;
						end else if (b1_r == `SMPP_OP_ENABLE_B1 && b2_r[7:5] == `SMPP_OP_LOCK_B2_TOP) begin
							if (!b2_r[1])
								lock1_r <= 1'b1;
							if (!b2_r[2])
								lock2_r <= 1'b1;
						end else if (is_prog_op(b1_r, `SMPP_OP_PWR_TOP)) begin
							state_r <= ST_WRITE;
							cnt_r <= WRITE_CYC;
							wr_is_ee_r <= 1'b0;
							wr_hi_r <= b1_r[3];
							wr_addr_r <= prog_addr(b2_r, b3_r);
							wr_data_r <= full_byte;
						end else if (b1_r == `SMPP_OP_EWR) begin
							state_r <= ST_WRITE;
							cnt_r <= WRITE_CYC;
							wr_is_ee_r <= 1'b1;
							wr_addr_r <= {3'b000, ee_addr(b2_r, b3_r)};
							wr_data_r <= full_byte;
						end
					end
				end
				ST_ERASE: begin
					if (erase_idx_r < `SMPP_PROG_WORDS) begin
						prog_lo_r[erase_idx_r[11:0]] <= `SMPP_ERASED;
						prog_hi_r[erase_idx_r[11:0]] <= `SMPP_ERASED;
						if (erase_idx_r < `SMPP_EE_BYTES)
							ee_r[erase_idx_r[8:0]] <= `SMPP_ERASED;
						erase_idx_r <= erase_idx_r + 13'd1;
					end
					if (cnt_r <= 32'd1 && erase_idx_r >= `SMPP_PROG_WORDS) begin
						state_r <= ST_IDLE;
						lock1_r <= 1'b0;
						lock2_r <= 1'b0;
					end else if (cnt_r > 32'd1)
						cnt_r <= cnt_r - 32'd1;
				end
				ST_WRITE: begin
					if (cnt_r <= 32'd1) begin
						state_r <= ST_IDLE;
						if (wr_is_ee_r)
							ee_r[wr_addr_r[8:0]] <= wr_data_r;
						else if (wr_hi_r)
							prog_hi_r[wr_addr_r] <= wr_data_r;
						else
							prog_lo_r[wr_addr_r] <= wr_data_r;
					end else
						cnt_r <= cnt_r - 32'd1;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
	// instruction byte stream to the user side, stall-safe
	smpp_buf2 u_buf (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.in_data_in(buf_data_r),
		.in_valid_in(buf_valid_r),
		.in_ready_out(buf_ready),
		.out_data_out(instr_byte_out),
		.out_valid_out(instr_valid_out),
		.out_ready_in(instr_ready_in)
	);
	// pin drive, session and busy flags
	assign miso_out = miso_r;
	assign miso_oe_out = in_prog;
	assign prog_mode_out = in_prog && enabled_r;
	assign busy_out = (state_r != ST_IDLE);
endmodule
`default_nettype wire

// ===== test/smpp_port_checker.sv
// concurrent checks on the programming port pins and handshake
`timescale 1ns/1ps
`default_nettype none
module smpp_port_checker (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic reset_n_pin_in,
	input wire logic sck_in,
	input wire logic mosi_in,
	input wire logic miso_out,
	input wire logic miso_oe_out,
	input wire logic prog_mode_out,
	input wire logic busy_out,
	input wire logic [7:0] instr_byte_out,
	input wire logic instr_valid_out,
	input wire logic instr_ready_in
);
	logic [15:0] busy_cnt_r;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// counts cycles of one busy stretch
	always_ff @(posedge clk_in) begin
		busy_cnt_r <= (busy_out && rst_n_in) ? busy_cnt_r + 16'h0001 : 16'h0000;
	end
	sequence s_pin_low;
		!reset_n_pin_in [*5];
	endsequence
	sequence s_pin_high;
		reset_n_pin_in [*5];
	endsequence
	property p_oe;
		s_pin_low |-> miso_oe_out;
	endproperty
	a_oe: assert property (p_oe) else $error("miso not driven in session");
	property p_exit;
		s_pin_high |-> !prog_mode_out && !miso_oe_out;
	endproperty
	a_exit: assert property (p_exit) else $error("session kept after pin high");
	property p_miso_edge;
		$changed(miso_out) && $past(miso_oe_out) |-> !$past(sck_in, 2) && !$past(sck_in);
	endproperty
	a_miso_edge: assert property (p_miso_edge) else $error("miso moved off falling edge");
	property p_stall;
		instr_valid_out && !instr_ready_in |=> instr_valid_out && $stable(instr_byte_out);
	endproperty
	a_stall: assert property (p_stall) else $error("byte lost under stall");
	property p_mode_need;
		$rose(prog_mode_out) |-> $past(miso_oe_out);
	endproperty
	a_mode_need: assert property (p_mode_need) else $error("enable outside session");
	property p_busy_mode;
		$rose(busy_out) |-> prog_mode_out;
	endproperty
	a_busy_mode: assert property (p_busy_mode) else $error("write without enable");
	property p_busy_min;
		$rose(busy_out) |-> busy_out [*8];
	endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy too short");
	property p_busy_max;
		busy_out |-> busy_cnt_r < 16'd9000;
	endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy never ends");
endmodule
bind smpp_port smpp_port_checker u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.reset_n_pin_in(reset_n_pin_in), .sck_in(sck_in), .mosi_in(mosi_in),
	.miso_out(miso_out), .miso_oe_out(miso_oe_out), .prog_mode_out(prog_mode_out),
	.busy_out(busy_out), .instr_byte_out(instr_byte_out),
	.instr_valid_out(instr_valid_out), .instr_ready_in(instr_ready_in));
`default_nettype wire

// ===== test/smpp_programmer.sv
// behavioural serial programmer driving clock, data and reset pin
`timescale 1ns/1ps
`default_nettype none
module smpp_programmer (
	input wire logic clk_in,
	input wire logic miso_in,
	output logic sck_out,
	output logic mosi_out,
	output logic reset_n_pin_out,
	output logic [15:0] cap_out,
	output logic done_out
);
	// clock and reset held low from power-up
	initial begin
		sck_out = 1'b0;
		mosi_out = 1'b0;
		reset_n_pin_out = 1'b0;
		cap_out = 16'h0000;
		done_out = 1'b0;
	end
	// one four-byte frame msb first, eight cycles a phase
	task automatic xfer(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			repeat (8) @(posedge clk_in);
			#1 sck_out = 1'b0;
			mosi_out = w[i];
			repeat (8) @(posedge clk_in);
			#1 cap_out = {cap_out[14:0], miso_in};
			sck_out = 1'b1;
		end
		repeat (8) @(posedge clk_in);
		#1 sck_out = 1'b0;
		mosi_out = ~mosi_out; // inverted line shows no stale bit
		done_out = 1'b1;
		@(posedge clk_in);
		#1 done_out = 1'b0;
	endtask
	// drives the reset pin after a clock edge
	task automatic pin(input logic v);
		@(posedge clk_in);
		#1 reset_n_pin_out = v;
	endtask
	// one extra rising pulse to slip the bit alignment by one
	task automatic nudge;
		repeat (8) @(posedge clk_in);
		#1 sck_out = 1'b1;
		repeat (8) @(posedge clk_in);
		#1 sck_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== test/test_serial_memory_programming_port.sv
// self-checking bench for the serial programming port
`timescale 1ns/1ps
`default_nettype none
module test_serial_memory_programming_port;
	localparam logic [23:0] SIGS = 24'h3c5a96; // signature values are arbitrary
	localparam int WCYC = 4096;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic ready = 1'b0;
	logic sck, mosi, pin_n, miso, done;
	logic [7:0] byte_o, d, p;
	logic [15:0] cap;
	logic [11:0] a;
	logic [17:0] e;
	integer seed, miscompares = 0, total_checks = 0;
	logic [7:0] bq[$];
	logic [17:0] rq[$];
	always #5 clk_in = ~clk_in;
	smpp_programmer u_prog (.clk_in(clk_in), .miso_in(miso), .sck_out(sck), .mosi_out(mosi),
		.reset_n_pin_out(pin_n), .cap_out(cap), .done_out(done));
	smpp_port #(.ERASE_CYC(64), .WRITE_CYC(WCYC), .SIG0(SIGS[7:0]), .SIG1(SIGS[15:8]),
		.SIG2(SIGS[23:16])) u_smpp_port (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.reset_n_pin_in(pin_n), .sck_in(sck), .mosi_in(mosi), .miso_out(miso),
		.miso_oe_out(), .prog_mode_out(), .busy_out(), .instr_byte_out(byte_o),
		.instr_valid_out(), .instr_ready_in(ready));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// notes the bytes and answer, then sends the frame
	task automatic op(input logic [31:0] w, input logic [17:0] x);
		for (int k = 3; k >= 0; k--) bq.push_back(w[8*k +: 8]);
		rq.push_back(x);
		u_prog.xfer(w);
	endtask
	task automatic wait_busy;
		int n;
		n = 0;
		while (u_smpp_port.busy_out !== 1'b0) begin
			@(posedge clk_in);
			n++;
			if (n > 10000) begin
				miscompares++;
				close_out;
			end
		end
	endtask
	// random stall on the byte side
	always @(posedge clk_in) #1 ready = $random(seed);
	// byte stream in order, none lost
	always @(posedge clk_in) begin
		if (rst_n_in && u_smpp_port.instr_valid_out && ready) check(byte_o, bq.pop_front());
	end
	// echo and read answer of each frame
	always @(posedge done) begin
		e = rq.pop_front();
		if (e[17]) check(cap[15:8], e[16:9]);
		if (e[8]) check(cap[7:0], e[7:0]);
	end
	initial begin
		seed = 32'h88041675;
		repeat (16) @(posedge clk_in);
		#1 rst_n_in = 1'b1;
		repeat (100) @(posedge clk_in); // entry wait scaled down
		op(32'hac800000, 18'h0);
		check({7'h0, u_smpp_port.busy_out}, 8'h00);
		$display("test refused erase done");
		op(32'hac530000, {1'b1, 8'h53, 9'h0});
		check({7'h0, u_smpp_port.prog_mode_out}, 8'h01);
		op(32'hac9f0000, 18'h0);
		wait_busy;
		u_prog.pin(1'b1);
		repeat (6) @(posedge clk_in);
		check({7'h0, u_smpp_port.prog_mode_out}, 8'h00);
		u_prog.pin(1'b0);
		repeat (100) @(posedge clk_in);
		// retry the enable after one extra clock pulse while the echo is missing
		for (int t = 0; t < 32; t++) begin
			if (t > 0)
				u_prog.nudge;
			op(32'hac530000, {1'b1, 8'h53, 9'h0});
			if (cap[15:8] === 8'h53)
				break;
		end
		$display("test enable and erase done");
		a = $random(seed);
		d = $random(seed) & 8'h3f;
		p = d | 8'h80;
		op({8'ha0, 7'h0, a[8], a[7:0], 8'h00}, {10'h1, 8'hff});
		op({8'h20, 4'h0, a, 8'h00}, {10'h1, 8'hff});
		op({8'hc0, 7'h0, a[8], a[7:0], d}, 18'h0);
		op({8'ha0, 7'h0, a[8], a[7:0], 8'h00}, {10'h1, 8'h80});
		repeat (1700) @(posedge clk_in);
		op({8'ha0, 7'h0, a[8], a[7:0], 8'h00}, {10'h1, 8'h7f});
		wait_busy;
		op({8'ha0, 7'h0, a[8], a[7:0], 8'h00}, {10'h1, d});
		$display("test eeprom write done");
		op({8'h48, 4'h0, a, p}, 18'h0);
		op({8'h28, 4'h0, a, 8'h00}, {10'h1, 8'h7f});
		wait_busy;
		op({8'h28, 4'h0, a, 8'h00}, {10'h1, p});
		op({8'h20, 4'h0, a, 8'h00}, {10'h1, 8'hff});
		$display("test program write done");
		op({8'hc0, 7'h0, a[8], a[7:0], 8'h80}, 18'h0);
		repeat (WCYC) @(posedge clk_in);
		op({8'ha0, 7'h0, a[8], a[7:0], 8'h00}, {10'h1, 8'h80});
		$display("test poll value write done");
		for (int k = 0; k < 3; k++) op({8'h30, 14'h0, k[1:0], 8'h00}, {10'h1, SIGS[8*k +: 8]});
		op(32'hacf90000, 18'h0);
		op(32'h30000000, {10'h1, 8'h00});
		$display("test signature and lock done");
		repeat (200) @(posedge clk_in);
		check({7'h0, bq.size() != 0}, 8'h00);
		close_out;
	end
endmodule
`default_nettype wire
